// >>> rtl/ccr_top.sv
// Configuration control and identification registers on APB.
// Assumes one 100 MHz clock, async active-low reset, inputs synchronous.
// How it works
// - Pin-remap lock blocks remap writes
// - Module-disable lock blocks disable writes
// - Lock bits change only after unlock
// - Debug port enable, resets to one
// - Two-wire TDO select, resets to one
// - Unimplemented bits read zero
// - Bits two and one read one
// - Identification register: revision and part id
// - Hold execution after any power-down
// - Low supply: brown-out reset and flag
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ccr_top
    import ccr_pkg::*;
#(
    parameter logic [CCR_HOLD_W-1:0] HOLD_CYCLES = CCR_HOLD_W'(CCR_HOLD_CYCLES)
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Peripheral write requests guarded by the locks
    input wire logic pin_remap_wr_req,
    input wire logic module_disable_wr_req,
    output logic pin_remap_wr_en,
    output logic module_disable_wr_en,
    // Configuration outputs
    output logic debug_port_enable,
    output logic two_wire_output_select,
    // Power and regulator
    input wire logic power_down,
    input wire logic supply_low,
    output logic exec_hold,
    output logic brownout_reset,
    // Interrupt
    output logic irq
);
    logic pin_lock, mod_lock, dbg_en, tdo_sel;
    logic next_pin_lock, next_mod_lock, next_dbg_en, next_tdo_sel;
    logic brownout_flag, next_brownout_flag;
    logic [CCR_EV_W-1:0] irq_status, next_irq_status, irq_enable, next_irq_enable;
    logic [31:0] next_prdata;
    logic next_pslverr, next_pready;
    logic supply_low_q, holding, hold_done, unlocked;
    logic acc, wr, rd, cfg_wr, key_wr, lock_change, reject;
    logic [CCR_EV_W-1:0] events;

    // Config register image; fixed ones and zeros fill the unused bits
    function automatic logic [31:0] config_image(input logic pl, input logic ml,
                                                 input logic de, input logic ts);
        logic [31:0] v;
        v = CCR_CONFIG_ONES;
        v[CCR_BIT_PIN_LOCK] = pl;
        v[CCR_BIT_MOD_LOCK] = ml;
        v[CCR_BIT_DBG_EN] = de;
        v[CCR_BIT_TDO_SEL] = ts;
        return v;
    endfunction

    // APB access decode: every access completes in its second access cycle, after one wait state
    assign acc = psel && penable && !pready;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign cfg_wr = wr && paddr == CCR_OFF_CONFIG;
    assign key_wr = wr && paddr == CCR_OFF_UNLOCK;
    assign lock_change = (pwdata[CCR_BIT_PIN_LOCK] != pin_lock) ||
                         (pwdata[CCR_BIT_MOD_LOCK] != mod_lock);

    ccr_unlock u_unlock (
        .pclk(pclk),
        .presetn(presetn),
        .key_wr(key_wr),
        .key_data(pwdata),
        .consume(cfg_wr),
        .unlocked(unlocked)
    );

    ccr_hold #(.HOLD_CYCLES(HOLD_CYCLES)) u_hold (
        .pclk(pclk),
        .presetn(presetn),
        .power_down(power_down),
        .holding(holding),
        .done_pulse(hold_done)
    );

    // Config bits: lock bits only move with an open unlock
    always_comb begin
        next_pin_lock = pin_lock;
        next_mod_lock = mod_lock;
        next_dbg_en = dbg_en;
        next_tdo_sel = tdo_sel;
        reject = 1'b0;
        if (cfg_wr) begin
            next_dbg_en = pwdata[CCR_BIT_DBG_EN];
            next_tdo_sel = pwdata[CCR_BIT_TDO_SEL];
            if (unlocked) begin
                next_pin_lock = pwdata[CCR_BIT_PIN_LOCK];
                next_mod_lock = pwdata[CCR_BIT_MOD_LOCK];
            end else begin
                reject = lock_change;
            end
        end
        // Other bits of pwdata are simply dropped
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_lock <= CCR_RST_PIN_LOCK;
            mod_lock <= CCR_RST_MOD_LOCK;
            dbg_en <= CCR_RST_DBG_EN;
            tdo_sel <= CCR_RST_TDO_SEL;
        end else begin
            pin_lock <= next_pin_lock;
            mod_lock <= next_mod_lock;
            dbg_en <= next_dbg_en;
            tdo_sel <= next_tdo_sel;
        end
    end

    // Brown-out flag, sticky; set wins over a write-one clear
    assign events = {reject, hold_done, supply_low_q && !brownout_reset};
    always_comb begin
        next_brownout_flag = brownout_flag;
        if (wr && paddr == CCR_OFF_RESET_STATUS && pwdata[CCR_BIT_BROWNOUT])
            next_brownout_flag = 1'b0;
        if (supply_low_q) next_brownout_flag = 1'b1;
        next_irq_status = irq_status;
        if (wr && paddr == CCR_OFF_IRQ_CLEAR) next_irq_status = irq_status & ~pwdata[CCR_EV_W-1:0];
        next_irq_status = next_irq_status | events;
        next_irq_enable = irq_enable;
        if (wr && paddr == CCR_OFF_IRQ_ENABLE) next_irq_enable = pwdata[CCR_EV_W-1:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brownout_flag <= 1'b0;
            irq_status <= '0;
            irq_enable <= '0;
            supply_low_q <= 1'b0;
        end else begin
            brownout_flag <= next_brownout_flag;
            irq_status <= next_irq_status;
            irq_enable <= next_irq_enable;
            supply_low_q <= supply_low;
        end
    end

    // Read mux and completion; unmapped addresses answer with pslverr
    always_comb begin
        next_prdata = '0;
        next_pslverr = 1'b0;
        next_pready = acc;
        if (acc) begin
            case (paddr)
                CCR_OFF_CONFIG: next_prdata = config_image(pin_lock, mod_lock, dbg_en, tdo_sel);
                CCR_OFF_IDENT: next_prdata = {CCR_REVISION, CCR_PART_ID};
                CCR_OFF_UNLOCK: next_prdata = '0;
                CCR_OFF_RESET_STATUS: next_prdata[CCR_BIT_BROWNOUT] = brownout_flag;
                CCR_OFF_IRQ_STATUS: next_prdata[CCR_EV_W-1:0] = irq_status;
                CCR_OFF_IRQ_ENABLE: next_prdata[CCR_EV_W-1:0] = irq_enable;
                CCR_OFF_IRQ_CLEAR: next_prdata = '0;
                CCR_OFF_HOLD_STATUS: next_prdata[0] = holding;
                default: next_pslverr = 1'b1;
            endcase
            if (!rd) next_prdata = '0;
            if (wr && (paddr == CCR_OFF_IDENT || paddr == CCR_OFF_IRQ_STATUS
                       || paddr == CCR_OFF_HOLD_STATUS)) next_pslverr = 1'b1;
        end
    end

    // Output registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            pin_remap_wr_en <= 1'b0;
            module_disable_wr_en <= 1'b0;
            debug_port_enable <= CCR_RST_DBG_EN;
            two_wire_output_select <= CCR_RST_TDO_SEL;
            exec_hold <= 1'b1;
            brownout_reset <= 1'b0;
            irq <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            pin_remap_wr_en <= pin_remap_wr_req && !pin_lock;
            module_disable_wr_en <= module_disable_wr_req && !mod_lock;
            debug_port_enable <= dbg_en;
            two_wire_output_select <= tdo_sel;
            exec_hold <= holding;
            brownout_reset <= supply_low_q;
            irq <= |(next_irq_status & next_irq_enable);
        end
    end

    // Checks
    // Remap writes are held back while the pin-remap lock is set
    a_pin_lock_gate: assert property (@(posedge pclk) disable iff (!presetn)
        pin_lock && pin_remap_wr_req |=> !pin_remap_wr_en)
        else $error("remap write passed lock");

    // Remap writes pass one cycle later while the lock is clear
    a_pin_lock_open: assert property (@(posedge pclk) disable iff (!presetn)
        !pin_lock && pin_remap_wr_req |=> pin_remap_wr_en)
        else $error("remap write dropped");

    // Module-disable writes are held back while locked
    a_mod_lock_gate: assert property (@(posedge pclk) disable iff (!presetn)
        mod_lock && module_disable_wr_req |=> !module_disable_wr_en)
        else $error("disable write passed");

    // Module-disable writes pass while unlocked
    a_mod_lock_open: assert property (@(posedge pclk) disable iff (!presetn)
        !mod_lock && module_disable_wr_req |=> module_disable_wr_en)
        else $error("disable write dropped");

    // A config write without an open unlock leaves both locks alone
    a_lock_needs_unlock: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_wr && !unlocked |=> $stable(pin_lock) && $stable(mod_lock))
        else $error("lock moved without unlock");

    // With the unlock open the locks take the written bits
    a_lock_with_unlock: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_wr && unlocked |=> pin_lock == $past(pwdata[CCR_BIT_PIN_LOCK])
            && mod_lock == $past(pwdata[CCR_BIT_MOD_LOCK]))
        else $error("lock ignored unlock");

    // Every config write spends the unlock, so the next one needs new keys
    a_unlock_spent: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_wr |=> !unlocked)
        else $error("unlock not spent");

    // Debug enable output follows the written bit two edges on
    a_dbg_follows: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_wr |=> ##1 debug_port_enable == $past(pwdata[CCR_BIT_DBG_EN], 2))
        else $error("debug enable wrong");

    // Two-wire output select follows the written bit two edges on
    a_tdo_follows: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_wr |=> ##1 two_wire_output_select == $past(pwdata[CCR_BIT_TDO_SEL], 2))
        else $error("tdo select wrong");

    // Unimplemented config bits read as zero
    a_cfg_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
        rd && paddr == CCR_OFF_CONFIG |=> (prdata & 32'hffff_cff0) == 32'h0000_0000)
        else $error("zero bits wrong");

    // Bits two and one of the config word read as one
    a_cfg_read_ones: assert property (@(posedge pclk) disable iff (!presetn)
        rd && paddr == CCR_OFF_CONFIG |=> prdata[2:1] == 2'b11)
        else $error("one bits wrong");

    // Revision field of the identification word
    a_ident_read: assert property (@(posedge pclk) disable iff (!presetn)
        rd && paddr == CCR_OFF_IDENT |=> prdata[31:CCR_REV_LSB] == CCR_REVISION)
        else $error("revision wrong");

    // Part identifier field of the identification word
    a_part_id_read: assert property (@(posedge pclk) disable iff (!presetn)
        rd && paddr == CCR_OFF_IDENT |=> prdata[CCR_REV_LSB-1:0] == CCR_PART_ID)
        else $error("part id wrong");

    // Writes to the identification word are refused
    a_ident_no_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == CCR_OFF_IDENT |=> pslverr)
        else $error("ident write accepted");

    // Execution stays held while powered down
    a_hold_in_pd: assert property (@(posedge pclk) disable iff (!presetn)
        power_down |=> exec_hold)
        else $error("no hold in power-down");

    // Execution is still held just after power-down ends
    a_hold_after_pd: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(power_down) |=> exec_hold)
        else $error("no hold after power-down");

    // Low supply raises the reset pulse and the flag two edges on
    a_brownout_flag: assert property (@(posedge pclk) disable iff (!presetn)
        supply_low |=> ##1 brownout_flag && brownout_reset)
        else $error("brown-out not flagged");

    // The flag only drops on a write of one to its bit
    a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        brownout_flag && !(wr && paddr == CCR_OFF_RESET_STATUS && pwdata[CCR_BIT_BROWNOUT])
            |=> brownout_flag)
        else $error("brown-out flag lost");

    // A config write stores only its implemented fields
    a_reserved_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_wr |=> $stable(irq_enable) && dbg_en == $past(pwdata[CCR_BIT_DBG_EN])
            && tdo_sel == $past(pwdata[CCR_BIT_TDO_SEL]))
        else $error("reserved bits stored");
endmodule // ccr_top
`default_nettype wire

// >>> rtl/ccr_pkg.sv
// Constants shared by the configuration control block and its helpers.
// Assumes a 32-bit APB register bus and a single 100 MHz clock.
package ccr_pkg;
    // Register byte offsets
    localparam logic [7:0] CCR_OFF_CONFIG = 8'h00;
    localparam logic [7:0] CCR_OFF_IDENT = 8'h04;
    localparam logic [7:0] CCR_OFF_UNLOCK = 8'h08;
    localparam logic [7:0] CCR_OFF_RESET_STATUS = 8'h0c;
    localparam logic [7:0] CCR_OFF_IRQ_STATUS = 8'h10;
    localparam logic [7:0] CCR_OFF_IRQ_ENABLE = 8'h14;
    localparam logic [7:0] CCR_OFF_IRQ_CLEAR = 8'h18;
    localparam logic [7:0] CCR_OFF_HOLD_STATUS = 8'h1c;
    // Config control field positions
    localparam int CCR_BIT_PIN_LOCK = 13;
    localparam int CCR_BIT_MOD_LOCK = 12;
    localparam int CCR_BIT_DBG_EN = 3;
    localparam int CCR_BIT_TDO_SEL = 0;
    localparam logic [31:0] CCR_CONFIG_ONES = 32'h0000_0006;
    // Reset values
    localparam logic CCR_RST_PIN_LOCK = 1'b0;
    localparam logic CCR_RST_MOD_LOCK = 1'b0;
    localparam logic CCR_RST_DBG_EN = 1'b1;
    localparam logic CCR_RST_TDO_SEL = 1'b1;
    // Identification fields
    localparam int CCR_REV_LSB = 28;
    localparam logic [3:0] CCR_REVISION = 4'h1;  // Arbitrary value
    localparam logic [27:0] CCR_PART_ID = 28'h0a5_c3e1;  // Arbitrary value
    // Unlock keys, written in order to the unlock register
    localparam logic [31:0] CCR_KEY1 = 32'haa99_6655;
    localparam logic [31:0] CCR_KEY2 = 32'h5566_99aa;
    // Reset status and interrupt bit positions
    localparam int CCR_BIT_BROWNOUT = 1;
    localparam int CCR_EV_BROWNOUT = 0;
    localparam int CCR_EV_HOLD_DONE = 1;
    localparam int CCR_EV_REJECT = 2;
    localparam int CCR_EV_W = 3;
    // Start-up hold: time in ns and cycles at 100 MHz
    localparam int CCR_CLK_PERIOD_NS = 10;
    localparam int CCR_HOLD_NS = 1000;
    localparam int CCR_HOLD_CYCLES = (CCR_HOLD_NS + CCR_CLK_PERIOD_NS - 1) / CCR_CLK_PERIOD_NS;
    localparam int CCR_HOLD_W = 16;
    typedef enum logic [1:0] {CCR_UL_IDLE, CCR_UL_KEY1, CCR_UL_OPEN} ccr_unlock_t;
endpackage

// >>> rtl/ccr_unlock.sv
// Two-key unlock sequencer; opens a single write to the lock bits.
// Assumes key writes and the consuming write are presented as one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module ccr_unlock
    import ccr_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Key writes and consumption
    input wire logic key_wr,
    input wire logic [31:0] key_data,
    input wire logic consume,
    // State
    output logic unlocked
);
    ccr_unlock_t state, next_state;

    // Any wrong key drops back to idle; a config write spends the unlock
    always_comb begin
        next_state = state;
        case (state)
            CCR_UL_IDLE: if (key_wr && key_data == CCR_KEY1) next_state = CCR_UL_KEY1;
            CCR_UL_KEY1: if (key_wr) begin
                next_state = (key_data == CCR_KEY2) ? CCR_UL_OPEN : CCR_UL_IDLE;
            end
            CCR_UL_OPEN: begin
                if (consume) next_state = CCR_UL_IDLE;
                else if (key_wr) next_state = CCR_UL_IDLE;
            end
            default: next_state = CCR_UL_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) state <= CCR_UL_IDLE;
        else state <= next_state;
    end

    assign unlocked = (state == CCR_UL_OPEN);
endmodule // ccr_unlock
`default_nettype wire

// >>> rtl/ccr_hold.sv
// Start-up hold-off timer: holds execution after any power-down release.
// Assumes power_down is a level synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module ccr_hold
    import ccr_pkg::*;
#(
    parameter logic [CCR_HOLD_W-1:0] HOLD_CYCLES = CCR_HOLD_W'(CCR_HOLD_CYCLES)
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Power state
    input wire logic power_down,
    // Status
    output logic holding,
    output logic done_pulse
);
    logic [CCR_HOLD_W-1:0] count, next_count;

    // Reload while powered down, count down after; starts full out of reset
    always_comb begin
        next_count = count;
        if (power_down) next_count = HOLD_CYCLES;
        else if (count != '0) next_count = count - 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) count <= HOLD_CYCLES;
        else count <= next_count;
    end

    assign holding = (count != '0) || power_down;
    assign done_pulse = (count == 1) && !power_down;
endmodule // ccr_hold
`default_nettype wire

// >>> tb/test_ccr_top.sv
// Self-checking bench for the configuration control register block.
// Assumes the package constants and a short start-up hold of four cycles.
`timescale 1ns/1ps
`default_nettype none
module test_ccr_top;
    import ccr_pkg::*;
    localparam logic [CCR_HOLD_W-1:0] HOLD = 16'h0004;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pin_remap_wr_req = 1'b0;
    logic module_disable_wr_req = 1'b0;
    logic pin_remap_wr_en;
    logic module_disable_wr_en;
    logic debug_port_enable;
    logic two_wire_output_select;
    logic power_down = 1'b0;
    logic supply_low = 1'b0;
    logic exec_hold;
    logic brownout_reset;
    logic irq;
    int errors = 0;
    int tests_run = 0;

    ccr_top #(.HOLD_CYCLES(HOLD)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_remap_wr_req(pin_remap_wr_req),
        .module_disable_wr_req(module_disable_wr_req), .pin_remap_wr_en(pin_remap_wr_en),
        .module_disable_wr_en(module_disable_wr_en), .debug_port_enable(debug_port_enable),
        .two_wire_output_select(two_wire_output_select), .power_down(power_down),
        .supply_low(supply_low), .exec_hold(exec_hold), .brownout_reset(brownout_reset),
        .irq(irq));

    // 100 MHz clock
    always #5 pclk = ~pclk;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; an idle edge follows so strobes never toggle twice in a step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) errors++;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        check("write error", 32'(e), 32'(ee));
    endtask

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x, input logic ee);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(nm, r, x);
        check("read error", 32'(e), 32'(ee));
    endtask

    // Both peripheral write requests for one cycle, enables looked at a cycle later
    task automatic gate(input logic xp, input logic xm);
        pin_remap_wr_req <= 1'b1;
        module_disable_wr_req <= 1'b1;
        @(posedge pclk);
        pin_remap_wr_req <= 1'b0;
        module_disable_wr_req <= 1'b0;
        @(posedge pclk);
        check("pin_remap_wr_en", 32'(pin_remap_wr_en), 32'(xp));
        check("module_disable_wr_en", 32'(module_disable_wr_en), 32'(xm));
    endtask

    task automatic t_reset;
        check("exec_hold", 32'(exec_hold), 32'h1);
        check("debug_port_enable", 32'(debug_port_enable), 32'h1);
        check("two_wire_output_select", 32'(two_wire_output_select), 32'h1);
        rd("config_control", CCR_OFF_CONFIG, 32'h0000_000f, 1'b0);
        rd("revision_and_part_id", CCR_OFF_IDENT, {CCR_REVISION, CCR_PART_ID}, 1'b0);
        wr(CCR_OFF_IDENT, 32'h0, 1'b1);
        rd("revision_and_part_id", CCR_OFF_IDENT, {CCR_REVISION, CCR_PART_ID}, 1'b0);
        rd("unmapped", 8'h40, 32'h0, 1'b1);
        rd("unlock read", CCR_OFF_UNLOCK, 32'h0, 1'b0);
        wr(CCR_OFF_IRQ_STATUS, 32'h0, 1'b1);
        wr(CCR_OFF_HOLD_STATUS, 32'h0, 1'b1);
        gate(1'b1, 1'b1);
        $display("test reset done");
    endtask

    // Lock bits refused without the key pair; other bits written anyway
    task automatic t_nolock;
        wr(CCR_OFF_IRQ_CLEAR, 32'h0000_0007, 1'b0);
        wr(CCR_OFF_CONFIG, 32'hffff_ffff, 1'b0);
        rd("config_control", CCR_OFF_CONFIG, 32'h0000_000f, 1'b0);
        rd("irq status", CCR_OFF_IRQ_STATUS, 32'h0000_0004, 1'b0);
        wr(CCR_OFF_CONFIG, 32'h0, 1'b0);
        rd("config_control", CCR_OFF_CONFIG, 32'h0000_0006, 1'b0);
        check("debug_port_enable", 32'(debug_port_enable), 32'h0);
        check("two_wire_output_select", 32'(two_wire_output_select), 32'h0);
        wr(CCR_OFF_CONFIG, 32'h0000_0009, 1'b0);
        check("debug_port_enable", 32'(debug_port_enable), 32'h1);
        check("two_wire_output_select", 32'(two_wire_output_select), 32'h1);
        $display("test nolock done");
    endtask

    // Each lock in turn, set after a valid unlock, then a stray write without keys
    task automatic t_locks;
        logic [31:0] v;
        for (int i = 0; i < 2; i++) begin
            v = (i == 0) ? 32'h0000_2009 : 32'h0000_1009;
            wr(CCR_OFF_UNLOCK, CCR_KEY1, 1'b0);
            wr(CCR_OFF_UNLOCK, CCR_KEY2, 1'b0);
            wr(CCR_OFF_CONFIG, v, 1'b0);
            rd("config_control", CCR_OFF_CONFIG, v | 32'h6, 1'b0);
            gate(i[0], ~i[0]);
            wr(CCR_OFF_CONFIG, 32'h0000_0009, 1'b0);
            rd("config_control", CCR_OFF_CONFIG, v | 32'h6, 1'b0);
        end
        // A wrong key between the pair drops the unlock
        wr(CCR_OFF_UNLOCK, CCR_KEY1, 1'b0);
        wr(CCR_OFF_UNLOCK, 32'h0, 1'b0);
        wr(CCR_OFF_UNLOCK, CCR_KEY2, 1'b0);
        wr(CCR_OFF_CONFIG, 32'h0000_0009, 1'b0);
        rd("config_control", CCR_OFF_CONFIG, 32'h0000_100f, 1'b0);
        wr(CCR_OFF_UNLOCK, CCR_KEY1, 1'b0);
        wr(CCR_OFF_UNLOCK, CCR_KEY2, 1'b0);
        wr(CCR_OFF_CONFIG, 32'h0000_0009, 1'b0);
        gate(1'b1, 1'b1);
        $display("test locks done");
    endtask

    // Low supply: reset pulse, sticky flag, interrupt raised, masked and cleared
    task automatic t_brownout;
        wr(CCR_OFF_IRQ_CLEAR, 32'h0000_0007, 1'b0);
        wr(CCR_OFF_IRQ_ENABLE, 32'h0000_0001, 1'b0);
        supply_low <= 1'b1;
        repeat (4) @(posedge pclk);
        check("brownout_reset", 32'(brownout_reset), 32'h1);
        supply_low <= 1'b0;
        rd("reset_status", CCR_OFF_RESET_STATUS, 32'h0000_0002, 1'b0);
        rd("irq status", CCR_OFF_IRQ_STATUS, 32'h0000_0001, 1'b0);
        check("irq", 32'(irq), 32'h1);
        wr(CCR_OFF_IRQ_ENABLE, 32'h0, 1'b0);
        check("irq masked", 32'(irq), 32'h0);
        wr(CCR_OFF_IRQ_ENABLE, 32'h0000_0001, 1'b0);
        check("irq", 32'(irq), 32'h1);
        wr(CCR_OFF_IRQ_CLEAR, 32'h0000_0001, 1'b0);
        wr(CCR_OFF_RESET_STATUS, 32'h0000_0002, 1'b0);
        rd("reset_status", CCR_OFF_RESET_STATUS, 32'h0, 1'b0);
        check("irq cleared", 32'(irq), 32'h0);
        check("brownout_reset", 32'(brownout_reset), 32'h0);
        $display("test brownout done");
    endtask

    // Wake from power-down: hold lasts the parameter count, then a done event
    task automatic t_hold;
        wr(CCR_OFF_IRQ_CLEAR, 32'h0000_0007, 1'b0);
        power_down <= 1'b1;
        repeat (3) @(posedge pclk);
        check("exec_hold", 32'(exec_hold), 32'h1);
        power_down <= 1'b0;
        repeat (int'(HOLD) + 1) @(posedge pclk);
        check("exec_hold", 32'(exec_hold), 32'h1);
        repeat (2) @(posedge pclk);
        check("exec_hold", 32'(exec_hold), 32'h0);
        rd("irq status", CCR_OFF_IRQ_STATUS, 32'h0000_0002, 1'b0);
        rd("hold status", CCR_OFF_HOLD_STATUS, 32'h0, 1'b0);
        $display("test hold done");
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_nolock();
        t_locks();
        t_brownout();
        t_hold();
        end_sim();
    end

    // Run takes well under a thousand cycles; this cuts a hang short
    initial begin
        #100000;
        errors++;
        end_sim();
    end
endmodule // test_ccr_top
`default_nettype wire
